/* File: meter_scaling_pkg.sv */
// meter register scaling package: register map, field layouts, reset values, timing
`default_nettype none
package meter_scaling_pkg;
    // measurement registers (scaled by the data scalar, except PF)
    localparam logic [15:0] ADDR_ENERGY_LO = 16'hABE1;
    localparam logic [15:0] ADDR_ENERGY_HI = 16'hABE2;
    localparam logic [15:0] ADDR_POWER = 16'hABE3;
    localparam logic [15:0] ADDR_AMPS = 16'hABE4;
    localparam logic [15:0] ADDR_VOLTS = 16'hABE5;
    localparam logic [15:0] ADDR_PF = 16'hABE6;
    localparam logic [15:0] ADDR_PEAK = 16'hABE7;
    // configuration registers
    localparam logic [15:0] ADDR_DEMAND_WIN = 16'hAE38;
    localparam logic [15:0] ADDR_LINE_FREQ = 16'hAE39;
    localparam logic [15:0] ADDR_SCALE = 16'hAE3A;
    localparam logic [15:0] ADDR_WIRING = 16'hAE3B;
    localparam logic [15:0] ADDR_CT_BASE = 16'hAE4C;
    localparam logic [15:0] ADDR_CT_LAST = 16'hAE54;
    localparam logic [15:0] ADDR_BAC_ID_LO = 16'hAE56;
    localparam logic [15:0] ADDR_BAC_ID_HI = 16'hAE57;
    localparam logic [15:0] ADDR_BAC_MAX_MASTER = 16'hAE58;
    localparam logic [15:0] ADDR_BAC_MAX_INFO = 16'hAE59;
    localparam logic [15:0] ADDR_BAC_COMMIT = 16'hAE5A;
    // field layout of the CT block: three words per CT
    localparam logic [3:0] CT_FIELDS = 4'h3;
    localparam logic [1:0] CT_F_TYPE = 2'h0;
    localparam logic [1:0] CT_F_AMPS = 2'h1;
    localparam logic [1:0] CT_F_SHIFT = 2'h2;
    // wiring codes
    localparam logic [1:0] WIRE_WYE = 2'h0;
    localparam logic [1:0] WIRE_DELTA = 2'h1;
    localparam logic [1:0] WIRE_SINGLE = 2'h2;
    localparam logic [2:0] ACTIVE_WYE = 3'h7;
    localparam logic [2:0] ACTIVE_DELTA = 3'h3;
    localparam logic [2:0] ACTIVE_SINGLE = 3'h1;
    // demand window limits and reset values
    localparam logic [5:0] DEMAND_WIN_MIN = 6'h01;
    localparam logic [5:0] DEMAND_WIN_MAX = 6'h3C;
    localparam logic [5:0] DEMAND_WIN_RST = 6'h0F;
    localparam logic [15:0] SCALE_RST = 16'h0003;
    localparam logic [15:0] CT_TYPE_RST = 16'h0000;
    localparam logic [15:0] CT_AMPS_RST = 16'h0064;
    localparam logic [15:0] PHASE_SHIFT_RST = 16'h006E; // hundredths of a degree
    localparam logic [21:0] BAC_ID_RST = 22'h000000;
    localparam logic [7:0] BAC_MAX_MASTER_RST = 8'h7F;
    localparam logic [7:0] BAC_MAX_INFO_RST = 8'h01;
    // scalar code to power-of-ten divisor exponent; raw inputs are in finest units
    localparam logic [2:0] SCALE_CODE_TOP = 3'h6;
    localparam logic [2:0] PWR_EXP [0:6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    localparam logic [2:0] AMP_EXP [0:6] = '{3'h0, 3'h1, 3'h1, 3'h1, 3'h2, 3'h2, 3'h2};
    localparam logic [2:0] VOLT_EXP [0:6] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h1};
    localparam logic [23:0] POW10 [0:7] = '{24'h000001, 24'h00000A, 24'h000064, 24'h0003E8,
                                            24'h002710, 24'h0186A0, 24'h0F4240, 24'h989680};
    // timing
    localparam longint unsigned CLK_HZ = 100_000_000;
    localparam longint unsigned MINUTE_S = 60;
    localparam longint unsigned MINUTE_CYCLES = MINUTE_S * CLK_HZ;
    localparam longint unsigned LINE_HZ_50 = 50;
    localparam longint unsigned LINE_HZ_60 = 60;
    localparam logic [20:0] LINE_PERIOD_50 = 21'(CLK_HZ / LINE_HZ_50);
    localparam logic [20:0] LINE_PERIOD_60 = 21'(CLK_HZ / LINE_HZ_60);
    localparam logic [5:0] MINUTES_PER_HOUR = 6'h3C;

    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [15:0] wdata;
    } reg_req_t;
    typedef struct packed {
        logic ack;
        logic err;
        logic [15:0] rdata;
    } reg_rsp_t;
    // raw units: energy 1e-5 kWh, power 1e-5 kW, amps .01 A, volts .1 V, pf .01
    typedef struct packed {
        logic [47:0] energy;
        logic [31:0] power;
        logic [23:0] amps;
        logic [23:0] volts;
        logic [7:0] pf;
    } meas_t;
    typedef struct packed {
        logic [15:0] ctype;
        logic [15:0] amps;
        logic [15:0] shift;
    } ct_cfg_t;
    typedef struct packed {
        logic [21:0] dev_id;
        logic [7:0] max_master;
        logic [7:0] max_info;
    } bac_cfg_t;
endpackage
`default_nettype wire

/* File: demand_window.sv */
// moving-window demand averager with peak hold
`default_nettype none
module demand_window
    import meter_scaling_pkg::*;
#(
    parameter int WIN_MAX = 60
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic [5:0] win_len,
    input wire logic [47:0] energy,
    output logic [31:0] demand,
    output logic [31:0] peak
);
    if (WIN_MAX < 1 || WIN_MAX > 63) begin : g_chk
        $error("demand_window: WIN_MAX out of range");
    end

    typedef struct packed {
        logic primed;
        logic [47:0] last_energy;
        logic [WIN_MAX-1:0][31:0] slot;
        logic [5:0] wptr;
        logic [31:0] demand;
        logic [31:0] peak;
    } dw_state_t;

    dw_state_t st;
    dw_state_t next_st;

    // per-minute deltas land in a ring; the sum walks back win_len slots
    always_comb begin
        logic [37:0] sum;
        logic [43:0] avg;
        int idx;
        sum = '0;
        avg = '0;
        idx = 0;
        next_st = st;
        if (tick) begin
            next_st.primed = 1'b1;
            next_st.last_energy = energy;
            if (st.primed) begin
                next_st.slot[st.wptr] = 32'(energy - st.last_energy);
                next_st.wptr = (st.wptr == 6'(WIN_MAX - 1)) ? '0 : st.wptr + 6'h01;
                for (int i = 0; i < WIN_MAX; i++) begin
                    idx = int'(st.wptr) - i;
                    if (idx < 0) begin
                        idx = idx + WIN_MAX;
                    end
                    if (i < int'(win_len)) begin
                        sum = sum + 38'(next_st.slot[idx]);
                    end
                end
                // minutes of energy scaled to an hourly rate over the window
                avg = (44'(sum) * 44'(MINUTES_PER_HOUR)) / 44'(win_len);
                next_st.demand = 32'(avg);
                if (32'(avg) > st.peak) begin
                    next_st.peak = 32'(avg);
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign demand = st.demand;
    assign peak = st.peak;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    AST_PEAK_MONO: assert property (!tick |=> $stable(st.peak))
        else $error("peak changed without a minute tick");
    AST_PEAK_COVERS: assert property (tick && st.primed |=> st.peak >= st.demand)
        else $error("peak below fresh demand");
endmodule
`default_nettype wire

/* File: meter_data_register_scaling.sv */
// meter register bank: scaled measurement words, wiring/CT/BACnet setup, demand
`default_nettype none
module meter_data_register_scaling
    import meter_scaling_pkg::*;
#(
    parameter longint unsigned CYCLES_PER_MINUTE = MINUTE_CYCLES,
    parameter int WIN_MAX = 60
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire reg_req_t reg_req,
    output reg_rsp_t reg_rsp,
    input wire meas_t meas,
    output logic line50,
    output logic [20:0] line_period,
    output logic [5:0] demand_win,
    output logic minute_tick,
    output ct_cfg_t [2:0] ct_cfg,
    output logic [2:0] ct_active,
    output bac_cfg_t bac
);
    if (CYCLES_PER_MINUTE < 2 || CYCLES_PER_MINUTE > 64'h0000_000F_FFFF_FFFF) begin : g_chk_min
        $error("meter: CYCLES_PER_MINUTE out of range");
    end
    if (WIN_MAX != int'(DEMAND_WIN_MAX)) begin : g_chk_win
        $error("meter: WIN_MAX must match the largest demand window");
    end

    localparam logic [35:0] MIN_CNT_TOP = 36'(CYCLES_PER_MINUTE - 1);

    typedef struct packed {
        reg_rsp_t rsp;
        logic [15:0] hold_hi;
        logic [5:0] demand_win;
        logic line50;
        logic [20:0] line_period;
        logic [15:0] scale;
        logic [1:0] wiring;
        ct_cfg_t [2:0] ct;
        logic ct_touched;
        bac_cfg_t bac_stage;
        bac_cfg_t bac;
        logic [35:0] minute_cnt;
        logic tick;
    } state_t;

    state_t st;
    state_t next_st;
    logic [31:0] demand_raw;
    logic [31:0] peak_raw;

    // clip a scalar code to the table index; 6 and above share the last row
    function automatic logic [2:0] clip_code(input logic [15:0] code);
        return (code >= 16'(SCALE_CODE_TOP)) ? SCALE_CODE_TOP : code[2:0];
    endfunction

    // divide by a power of ten; every branch divides by a constant
    function automatic logic [47:0] div_pow10(input logic [47:0] v, input logic [2:0] e);
        logic [47:0] r;
        r = v;
        for (int k = 0; k < 8; k++) begin
            if (e == 3'(k)) begin
                r = v / 48'(POW10[k]);
            end
        end
        return r;
    endfunction

    // write one CT field, keeping the other two
    function automatic ct_cfg_t set_ct_field(input ct_cfg_t c, input logic [1:0] f, input logic [15:0] d);
        ct_cfg_t r;
        r = c;
        unique case (f)
            CT_F_TYPE: r.ctype = d;
            CT_F_AMPS: r.amps = d;
            default: r.shift = d;
        endcase
        return r;
    endfunction

    // read one CT field; lets the copy checks look only at the field that was written
    function automatic logic [15:0] ct_field_of(input ct_cfg_t c, input logic [1:0] f);
        unique case (f)
            CT_F_TYPE: return c.ctype;
            CT_F_AMPS: return c.amps;
            default: return c.shift;
        endcase
    endfunction

    // scaled views; bits above 16 (32 for energy) are simply lost when the scalar is too fine
    logic [2:0] code_idx;
    logic [47:0] energy_div;
    logic [31:0] energy_scaled;
    logic [15:0] power_scaled;
    logic [15:0] peak_scaled;
    logic [15:0] amps_scaled;
    logic [15:0] volts_scaled;
    logic [15:0] pf_scaled;
    assign code_idx = clip_code(st.scale);
    assign energy_div = div_pow10(meas.energy, PWR_EXP[code_idx]);
    assign energy_scaled = energy_div[31:0];
    assign power_scaled = 16'(div_pow10(48'(meas.power), PWR_EXP[code_idx]));
    assign peak_scaled = 16'(div_pow10(48'(peak_raw), PWR_EXP[code_idx]));
    assign amps_scaled = 16'(div_pow10(48'(meas.amps), AMP_EXP[code_idx]));
    assign volts_scaled = 16'(div_pow10(48'(meas.volts), VOLT_EXP[code_idx]));
    assign pf_scaled = 16'(meas.pf); // power factor stays at .01

    // CT block decode
    logic ct_hit;
    logic [3:0] ct_off;
    logic [1:0] ct_n;
    logic [1:0] ct_f;
    assign ct_hit = (reg_req.addr >= ADDR_CT_BASE) && (reg_req.addr <= ADDR_CT_LAST);
    assign ct_off = 4'(reg_req.addr - ADDR_CT_BASE);
    assign ct_n = 2'(ct_off / CT_FIELDS);
    assign ct_f = 2'(ct_off % CT_FIELDS);

    demand_window #(
        .WIN_MAX(WIN_MAX)
    ) u_demand (
        .core_clk(core_clk),
        .rst(rst),
        .tick(st.tick),
        .win_len(st.demand_win),
        .energy(meas.energy),
        .demand(demand_raw),
        .peak(peak_raw)
    );

    // next-state: minute timebase, line timing, register reads and writes
    always_comb begin
        next_st = st;
        next_st.rsp.ack = 1'b0;
        next_st.rsp.err = 1'b0;
        next_st.tick = 1'b0;
        if (st.minute_cnt == MIN_CNT_TOP) begin
            next_st.minute_cnt = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.minute_cnt = st.minute_cnt + 36'h1;
        end
        next_st.line_period = st.line50 ? LINE_PERIOD_50 : LINE_PERIOD_60;
        if (reg_req.valid) begin
            next_st.rsp.ack = 1'b1;
            next_st.rsp.rdata = '0; // unsigned words, upper bits zero
            if (reg_req.write) begin
                if (reg_req.addr == ADDR_DEMAND_WIN) begin
                    // out-of-range lengths are refused so the divider never sees zero
                    if (reg_req.wdata >= 16'(DEMAND_WIN_MIN) && reg_req.wdata <= 16'(DEMAND_WIN_MAX)) begin
                        next_st.demand_win = reg_req.wdata[5:0];
                    end else begin
                        next_st.rsp.err = 1'b1;
                    end
                end else if (reg_req.addr == ADDR_LINE_FREQ) begin
                    next_st.line50 = reg_req.wdata[0];
                end else if (reg_req.addr == ADDR_SCALE) begin
                    next_st.scale = reg_req.wdata;
                end else if (reg_req.addr == ADDR_WIRING) begin
                    if (reg_req.wdata[1:0] != 2'h3 && reg_req.wdata[15:2] == '0) begin
                        next_st.wiring = reg_req.wdata[1:0];
                    end else begin
                        next_st.rsp.err = 1'b1;
                    end
                end else if (ct_hit) begin
                    next_st.ct_touched = 1'b1;
                    next_st.ct[ct_n] = set_ct_field(st.ct[ct_n], ct_f, reg_req.wdata);
                    if (ct_n == 2'h0 && st.wiring == WIRE_WYE) begin
                        next_st.ct[1] = set_ct_field(st.ct[1], ct_f, reg_req.wdata);
                        next_st.ct[2] = set_ct_field(st.ct[2], ct_f, reg_req.wdata);
                    end else if (ct_n == 2'h0 && st.wiring == WIRE_DELTA) begin
                        next_st.ct[2] = set_ct_field(st.ct[2], ct_f, reg_req.wdata);
                    end
                end else if (reg_req.addr == ADDR_BAC_ID_LO) begin
                    next_st.bac_stage.dev_id[15:0] = reg_req.wdata;
                end else if (reg_req.addr == ADDR_BAC_ID_HI) begin
                    next_st.bac_stage.dev_id[21:16] = reg_req.wdata[5:0];
                end else if (reg_req.addr == ADDR_BAC_MAX_MASTER) begin
                    next_st.bac_stage.max_master = reg_req.wdata[7:0];
                end else if (reg_req.addr == ADDR_BAC_MAX_INFO) begin
                    next_st.bac_stage.max_info = reg_req.wdata[7:0];
                end else if (reg_req.addr == ADDR_BAC_COMMIT) begin
                    next_st.bac = st.bac_stage; // setup takes effect as one unit
                end else begin
                    next_st.rsp.err = 1'b1; // read-only or unmapped
                end
            end else begin
                if (reg_req.addr == ADDR_ENERGY_LO) begin
                    // low word read freezes the high word so the pair cannot tear
                    next_st.rsp.rdata = energy_scaled[15:0];
                    next_st.hold_hi = energy_scaled[31:16];
                end else if (reg_req.addr == ADDR_ENERGY_HI) begin
                    next_st.rsp.rdata = st.hold_hi;
                end else if (reg_req.addr == ADDR_POWER) begin
                    next_st.rsp.rdata = power_scaled;
                end else if (reg_req.addr == ADDR_AMPS) begin
                    next_st.rsp.rdata = amps_scaled;
                end else if (reg_req.addr == ADDR_VOLTS) begin
                    next_st.rsp.rdata = volts_scaled;
                end else if (reg_req.addr == ADDR_PF) begin
                    next_st.rsp.rdata = pf_scaled;
                end else if (reg_req.addr == ADDR_PEAK) begin
                    next_st.rsp.rdata = peak_scaled;
                end else if (reg_req.addr == ADDR_DEMAND_WIN) begin
                    next_st.rsp.rdata = 16'(st.demand_win);
                end else if (reg_req.addr == ADDR_LINE_FREQ) begin
                    next_st.rsp.rdata = 16'(st.line50);
                end else if (reg_req.addr == ADDR_SCALE) begin
                    next_st.rsp.rdata = st.scale;
                end else if (reg_req.addr == ADDR_WIRING) begin
                    next_st.rsp.rdata = 16'(st.wiring);
                end else if (ct_hit) begin
                    unique case (ct_f)
                        CT_F_TYPE: next_st.rsp.rdata = st.ct[ct_n].ctype;
                        CT_F_AMPS: next_st.rsp.rdata = st.ct[ct_n].amps;
                        default: next_st.rsp.rdata = st.ct[ct_n].shift;
                    endcase
                end else if (reg_req.addr == ADDR_BAC_ID_LO) begin
                    next_st.rsp.rdata = st.bac.dev_id[15:0];
                end else if (reg_req.addr == ADDR_BAC_ID_HI) begin
                    next_st.rsp.rdata = 16'(st.bac.dev_id[21:16]);
                end else if (reg_req.addr == ADDR_BAC_MAX_MASTER) begin
                    next_st.rsp.rdata = 16'(st.bac.max_master);
                end else if (reg_req.addr == ADDR_BAC_MAX_INFO) begin
                    next_st.rsp.rdata = 16'(st.bac.max_info);
                end else begin
                    next_st.rsp.err = 1'b1;
                end
            end
        end
    end

    // reset loads documented defaults, phase shift included
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.demand_win <= DEMAND_WIN_RST;
            st.line_period <= LINE_PERIOD_60;
            st.scale <= SCALE_RST;
            st.wiring <= WIRE_WYE;
            for (int i = 0; i < 3; i++) begin
                st.ct[i] <= '{ctype: CT_TYPE_RST, amps: CT_AMPS_RST, shift: PHASE_SHIFT_RST};
            end
            st.bac_stage <= '{dev_id: BAC_ID_RST, max_master: BAC_MAX_MASTER_RST, max_info: BAC_MAX_INFO_RST};
            st.bac <= '{dev_id: BAC_ID_RST, max_master: BAC_MAX_MASTER_RST, max_info: BAC_MAX_INFO_RST};
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from state flops; ct_active decoded from the wiring code
    assign reg_rsp = st.rsp;
    assign line50 = st.line50;
    assign line_period = st.line_period;
    assign demand_win = st.demand_win;
    assign minute_tick = st.tick;
    assign ct_cfg = st.ct;
    assign bac = st.bac;
    assign ct_active = (st.wiring == WIRE_WYE) ? ACTIVE_WYE :
                       (st.wiring == WIRE_DELTA) ? ACTIVE_DELTA : ACTIVE_SINGLE;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_read_lo;
        reg_req.valid && !reg_req.write && reg_req.addr == ADDR_ENERGY_LO;
    endsequence
    sequence s_read_hi;
        reg_req.valid && !reg_req.write && reg_req.addr == ADDR_ENERGY_HI;
    endsequence
    sequence s_ct1_write;
        reg_req.valid && reg_req.write && ct_hit && ct_n == 2'h0;
    endsequence

    AST_WIN_RANGE: assert property (st.demand_win >= DEMAND_WIN_MIN && st.demand_win <= DEMAND_WIN_MAX)
        else $error("demand window left 1..60");
    AST_WIN_REFUSE: assert property (reg_req.valid && reg_req.write && reg_req.addr == ADDR_DEMAND_WIN
                                     && reg_req.wdata > 16'(DEMAND_WIN_MAX) |=> $stable(st.demand_win) && reg_rsp.err)
        else $error("out-of-range window not refused");
    AST_LINE_PERIOD: assert property (st.line50 && $past(st.line50) |-> line_period == LINE_PERIOD_50)
        else $error("50 Hz timing not applied");
    AST_WYE_COPY: assert property (s_ct1_write and (st.wiring == WIRE_WYE) |=>
                                   ct_field_of(st.ct[1], $past(ct_f)) == $past(reg_req.wdata)
                                   && ct_field_of(st.ct[2], $past(ct_f)) == $past(reg_req.wdata))
        else $error("wye CT1 change not copied");
    AST_DELTA_COPY: assert property (s_ct1_write and (st.wiring == WIRE_DELTA) |=>
                                     ct_field_of(st.ct[2], $past(ct_f)) == $past(reg_req.wdata)
                                     && $stable(st.ct[1]) && ct_active == ACTIVE_DELTA)
        else $error("delta CT1 change not mirrored to CT3");
    AST_SHIFT_DEFAULT: assert property (!st.ct_touched |-> st.ct[0].shift == PHASE_SHIFT_RST
                                        && st.ct[2].shift == PHASE_SHIFT_RST)
        else $error("phase shift left default without a write");
    AST_PAIR_SNAPSHOT: assert property (s_read_lo ##1 s_read_hi |=> reg_rsp.rdata == $past(energy_scaled[31:16], 2))
        else $error("energy pair words from different instants");
    AST_PF_FIXED: assert property (reg_req.valid && !reg_req.write && reg_req.addr == ADDR_PF |=>
                                   reg_rsp.ack && reg_rsp.rdata == 16'($past(meas.pf)))
        else $error("power factor scaled by code");
    AST_TICK_PULSE: assert property (minute_tick |=> !minute_tick)
        else $error("minute tick wider than one cycle");
    AST_BAC_COMMIT: assert property (reg_req.valid && reg_req.write && reg_req.addr == ADDR_BAC_MAX_MASTER
                                     |=> $stable(bac))
        else $error("BACnet setup changed before send");
endmodule
`default_nettype wire

/* File: reg_master_model.sv */
// register master model: one read or write per call over the request/answer port
`default_nettype none
module reg_master_model
    import meter_scaling_pkg::*;
(
    input wire logic core_clk,
    input wire reg_rsp_t reg_rsp,
    output reg_req_t reg_req
);
    timeunit 1ns;
    timeprecision 1ps;
    initial reg_req = '0;
    // request stands one cycle only, since every valid cycle counts as a new request
    task automatic xfer(input logic wr, input logic [15:0] a, input logic [15:0] d,
                        output logic [15:0] rd, output logic er);
        logic got;
        got = 1'b0;
        rd = 16'hFFFF;
        er = 1'b1;
        @(posedge core_clk);
        reg_req <= '{1'b1, wr, a, d};
        @(posedge core_clk);
        reg_req <= '{1'b0, 1'b0, ~a, ~d}; // released lines show a changed pattern
        for (int i = 0; i < 3 && !got; i++) begin
            @(posedge core_clk);
            if (reg_rsp.ack === 1'b1) begin
                got = 1'b1;
                rd = reg_rsp.rdata;
                er = reg_rsp.err;
            end
        end
    endtask
endmodule
`default_nettype wire

/* File: meter_data_register_scaling_tb_top.sv */
// testbench for the meter register bank: reset values, scaling, pairing, wiring copy, refusals
`default_nettype none
module meter_data_register_scaling_tb_top;
    import meter_scaling_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, rst = 1'b1, line50, minute_tick, er;
    reg_req_t reg_req;
    reg_rsp_t reg_rsp;
    meas_t meas = '0;
    logic [20:0] line_period;
    logic [5:0] demand_win;
    ct_cfg_t [2:0] ct_cfg;
    logic [2:0] ct_active;
    bac_cfg_t bac;
    logic [15:0] rd, hi;
    int err_total = 0, checked = 0, cyc = 0;
    int pexp [0:7] = '{0, 2, 3, 4, 5, 6, 7, 7}; // code 6 and above divide by ten to the 7th
    meter_data_register_scaling #(.CYCLES_PER_MINUTE(20), .WIN_MAX(60)) uut (.core_clk(core_clk), .rst(rst),
        .reg_req(reg_req), .reg_rsp(reg_rsp), .meas(meas), .line50(line50), .line_period(line_period),
        .demand_win(demand_win), .minute_tick(minute_tick), .ct_cfg(ct_cfg), .ct_active(ct_active), .bac(bac));
    reg_master_model mst (.core_clk(core_clk), .reg_rsp(reg_rsp), .reg_req(reg_req));
    initial forever #5 core_clk = ~core_clk;
    // hang guard, sized well above the hundred-odd cycles the tests need
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            conclude();
        end
    end
    task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("counts: checked %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic t_reset();
        mst.xfer(1'b0, ADDR_SCALE, 16'h0, rd, er);
        chk("scale code", rd, SCALE_RST);
        chk("ct3 shift", ct_cfg[2].shift, 16'h006E);
        chk("active cts", ct_active, 3'h7);
        $display("test reset done");
    endtask
    task automatic t_scale();
        logic [47:0] p;
        @(posedge core_clk);
        meas.power <= 32'h3ADE_68B1;
        meas.energy <= 48'h0000_000D_1395;
        p = 48'h3ADE_68B1;
        for (int c = 0; c < 8; c++) begin
            mst.xfer(1'b1, ADDR_SCALE, 16'(c), rd, er);
            mst.xfer(1'b0, ADDR_POWER, 16'h0, rd, er);
            chk("power scaled", rd, 48'((p / (64'd10 ** pexp[c])) & 48'hFFFF));
        end
        mst.xfer(1'b1, ADDR_SCALE, 16'h0000, rd, er);
        mst.xfer(1'b0, ADDR_ENERGY_LO, 16'h0, rd, er);
        chk("energy low", rd, 48'h1395);
        @(posedge core_clk);
        meas.energy <= 48'h0000_0077_0000; // high word moves after the low read
        mst.xfer(1'b0, ADDR_ENERGY_HI, 16'h0, hi, er);
        chk("energy high", hi, 48'h000D);
        chk("energy pair", {hi, rd}, 48'h000D_1395);
        $display("test scale done");
    endtask
    task automatic t_wiring();
        mst.xfer(1'b1, ADDR_WIRING, 16'h0001, rd, er);
        mst.xfer(1'b1, ADDR_CT_BASE + 16'h1, 16'h00C8, rd, er);
        chk("delta active", ct_active, 3'h3);
        chk("delta ct3 amps", ct_cfg[2].amps, 16'h00C8);
        chk("delta ct2 amps", ct_cfg[1].amps, 16'h0064);
        mst.xfer(1'b1, ADDR_WIRING, 16'h0000, rd, er);
        mst.xfer(1'b1, ADDR_CT_BASE + 16'h2, 16'h012C, rd, er);
        chk("wye shifts", {ct_cfg[2].shift, ct_cfg[1].shift, ct_cfg[0].shift}, 48'h012C_012C_012C);
        $display("test wiring done");
    endtask
    task automatic t_config();
        logic [15:0] w [0:3] = '{16'h0000, 16'h003D, 16'h0001, 16'h003C};
        for (int i = 0; i < 4; i++) begin
            mst.xfer(1'b1, ADDR_DEMAND_WIN, w[i], rd, er);
            chk("window refusal", er, i < 2);
        end
        chk("window", demand_win, 6'h3C);
        mst.xfer(1'b1, ADDR_ENERGY_LO, 16'h0001, rd, er);
        chk("ro refusal", er, 1'b1);
        mst.xfer(1'b1, ADDR_LINE_FREQ, 16'h0001, rd, er);
        chk("line 50", line50, 1'b1);
        mst.xfer(1'b1, ADDR_BAC_ID_LO, 16'h1234, rd, er);
        chk("id before commit", bac.dev_id, 22'h0);
        mst.xfer(1'b1, ADDR_BAC_COMMIT, 16'h0001, rd, er);
        chk("id after commit", bac.dev_id, 22'h001234);
        $display("test config done");
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_scale();
        t_wiring();
        t_config();
        conclude();
    end
endmodule
`default_nettype wire
